// [hw/ssp_pkg.sv]
// Notes on behaviour
// R1: Each serial clock rising edge shifts the data bit into a 24-bit register.
// R2: Words arrive MSB first; the last two bits choose the target control register.
// R3: A latch strobe rising edge copies the shift register into one of six registers.
// R4: Chip enable high powers both sections; programmed power-down bits then rule.
// R5: Chip enable low powers down at once and tri-states both pump outputs.
// R6: Oscillator enable high keeps the oscillator buffer on regardless of chip enable.
// R7: Oscillator enable low turns the shared pin into the IF fast switch.
// R8: The RF fast pin is a fast switch, or a tri-stateable general output.
// R9: A setting picks the RF modulus 32/33 or 16/17, else 8/9 or 16/17.
// R10: Each charge pump current is programmable to 1 mA or 4 mA.
// R11: A powering-up or retuning write starts fastlock; a counter ends it.
// R12: Programmed power-down bits give a synchronous power-down beside the pin.
// R13: Extra bits before the strobe push the oldest ones out; last 24 kept.
package ssp_pkg;
  localparam int          WORD_W      = 24;
  localparam int          NUM_CTL     = 6;
  localparam int          SEL_LO      = 0;
  localparam int          SUB_LO      = 2;
  localparam logic [1:0]  SEL_EXT     = 2'h3;
  localparam logic [1:0]  SUB_BAD     = 2'h3;
  localparam logic [2:0]  CTL_RF      = 3'h0;
  localparam logic [2:0]  CTL_IF      = 3'h1;
  localparam logic [2:0]  CTL_PIN     = 3'h2;
  localparam logic [2:0]  CTL_EXT0    = 3'h3;
  localparam int          PD_BIT      = 23;
  localparam int          CUR_BIT     = 22;
  localparam int          PRE_BIT     = 21;
  localparam int          N_HI        = 20;
  localparam int          N_LO        = 2;
  localparam int          RF_GPO_BIT  = 23;
  localparam int          RF_GPO_VAL  = 22;
  localparam int          RF_GPO_TRI  = 21;
  localparam int          IF_GPO_BIT  = 20;
  localparam int          IF_GPO_VAL  = 19;
  localparam int          IF_GPO_TRI  = 18;
  localparam logic [23:0] CTL_RESET   = 24'h80_0000;
  localparam logic [23:0] CTL_PIN_RESET = 24'h00_0000;
  localparam int          ADDR_W      = 8;
  localparam logic [5:0]  IDX_STATUS  = 6'h06;
  localparam logic [5:0]  IDX_CONFIG  = 6'h07;
  localparam int          ST_CE       = 0;
  localparam int          ST_OSC      = 1;
  localparam int          ST_RF_PWR   = 2;
  localparam int          ST_IF_PWR   = 3;
  localparam int          ST_RF_FAST  = 4;
  localparam int          ST_IF_FAST  = 5;
  localparam int          ST_LOADS_LO = 8;
  localparam int          CFG_TMO_LO  = 0;
  localparam int          CFG_HF_BIT  = 16;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0040;
  localparam logic [31:0] CFG_MASK    = 32'h0001_ffff;
  localparam logic [5:0]  MOD_32      = 6'h20;
  localparam logic [5:0]  MOD_16      = 6'h10;
  localparam logic [5:0]  MOD_8       = 6'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// [hw/ssp_top.sv]
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module ssp_top
  import ssp_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Serial programming port.
  input  wire logic              serial_clk_i,
  input  wire logic              serial_data_i,
  input  wire logic              latch_strobe_i,
  // Power control pins.
  input  wire logic              chip_enable_i,
  input  wire logic              osc_buffer_enable_i,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Synthesizer controls.
  output logic                   rf_power_on_o,
  output logic                   if_power_on_o,
  output logic                   osc_buffer_on_o,
  output logic                   osc_out_mode_o,
  output logic                   rf_pump_out_oe_n_o,
  output logic                   if_pump_out_oe_n_o,
  output logic                   rf_pump_high_o,
  output logic                   if_pump_high_o,
  output logic [5:0]             rf_modulus_o,
  output logic [5:0]             if_modulus_o,
  // Fast switch pins.
  output logic                   rf_fast_switch_out_o,
  output logic                   rf_fast_switch_out_oe_n_o,
  output logic                   osc_out_or_if_fast_switch_o,
  output logic                   osc_out_or_if_fast_switch_oe_n_o
);

  logic              sck_s1_r, sck_s2_r, sck_s3_r, dat_s1_r, dat_s2_r;
  logic              le_s1_r, le_s2_r, le_s3_r, ce_s1_r, ce_s2_r, osc_s1_r, osc_s2_r;
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [WORD_W-1:0] ctl_r [NUM_CTL];
  logic [WORD_W-1:0] ctl_nxt [NUM_CTL];
  logic [7:0]        loads_r, loads_nxt;
  logic [15:0]       rf_cnt_r, rf_cnt_nxt, if_cnt_r, if_cnt_nxt;
  logic              sck_rise, le_rise, load_ok, rf_start, if_start;
  logic [2:0]        load_idx;
  logic [1:0]        load_sel, load_sub;
  logic [15:0]       tmo;
  logic              pwr_clear;
  logic              rf_pwr_nxt, if_pwr_nxt;
  logic              oscb_nxt, oscm_nxt, rfh_nxt, ifh_nxt, rff_nxt, rffoe_nxt, iff_nxt, iffoe_nxt;
  logic [5:0]        rfm_nxt, ifm_nxt;
  logic              awh_r, awh_nxt, wh_r, wh_nxt, awr_nxt, wr_nxt, bv_nxt, arr_nxt, rv_nxt;
  logic [ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0]       wd_r, wd_nxt, rd_nxt, cfg_r, cfg_nxt;
  logic [32:0]       rd_word;
  logic [3:0]        ws_r, ws_nxt;
  logic [1:0]        br_nxt, rr_nxt;

  // Pin synchronisers feed edge detection from the second stage on.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      {sck_s1_r, sck_s2_r, sck_s3_r, dat_s1_r, dat_s2_r} <= 5'h00;
      {le_s1_r, le_s2_r, le_s3_r, ce_s1_r, ce_s2_r, osc_s1_r, osc_s2_r} <= 7'h00;
    end
    else
    begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= {serial_clk_i, sck_s1_r, sck_s2_r};
      {dat_s1_r, dat_s2_r} <= {serial_data_i, dat_s1_r};
      {le_s1_r, le_s2_r, le_s3_r} <= {latch_strobe_i, le_s1_r, le_s2_r};
      {ce_s1_r, ce_s2_r} <= {chip_enable_i, ce_s1_r};
      {osc_s1_r, osc_s2_r} <= {osc_buffer_enable_i, osc_s1_r};
    end
  end

  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign le_rise  = le_s2_r & ~le_s3_r;
  // R2: last bits select
  assign load_sel = shift_r[SEL_LO +: 2];
  assign load_sub = shift_r[SUB_LO +: 2];
  assign load_idx = (load_sel == SEL_EXT) ? 3'(CTL_EXT0 + {1'b0, load_sub}) : {1'b0, load_sel};
  assign load_ok  = le_rise & ~((load_sel == SEL_EXT) & (load_sub == SUB_BAD));
  assign tmo      = cfg_r[CFG_TMO_LO +: 16];
  // Fastlock start: a write that powers up or retunes the section.
  assign rf_start = load_ok & (load_idx == CTL_RF) & ~shift_r[PD_BIT] & (ctl_r[CTL_RF][PD_BIT]
                    | (shift_r[N_HI:N_LO] != ctl_r[CTL_RF][N_HI:N_LO]));
  assign if_start = load_ok & (load_idx == CTL_IF) & ~shift_r[PD_BIT] & (ctl_r[CTL_IF][PD_BIT]
                    | (shift_r[N_HI:N_LO] != ctl_r[CTL_IF][N_HI:N_LO]));

  // Serial shifting, latching and fastlock timing.
  always_comb
  begin
    shift_nxt = shift_r;
    ctl_nxt   = ctl_r;
    loads_nxt = loads_r;
    // R1: shift on edge
    // R13: oldest bits drop
    if (sck_rise)
      shift_nxt = {shift_r[WORD_W-2:0], dat_s2_r};
    // R3: latch into target
    if (load_ok)
    begin
      ctl_nxt[load_idx] = shift_r;
      loads_nxt = loads_r + 8'h01;
    end
    // R11: counter ends fastlock
    rf_cnt_nxt = (rf_cnt_r != 16'h0000) ? 16'(rf_cnt_r - 16'h0001) : 16'h0000;
    if_cnt_nxt = (if_cnt_r != 16'h0000) ? 16'(if_cnt_r - 16'h0001) : 16'h0000;
    if (rf_start)
      rf_cnt_nxt = tmo;
    if (if_start)
      if_cnt_nxt = tmo;
    if (!ce_s2_r)
    begin
      rf_cnt_nxt = 16'h0000;
      if_cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shift_r  <= 24'h00_0000;
      loads_r  <= 8'h00;
      rf_cnt_r <= 16'h0000;
      if_cnt_r <= 16'h0000;
      for (int i = 0; i < NUM_CTL; i++)
        ctl_r[i] <= (i == int'(CTL_PIN)) ? CTL_PIN_RESET : CTL_RESET;
    end
    else
    begin
      shift_r  <= shift_nxt;
      loads_r  <= loads_nxt;
      rf_cnt_r <= rf_cnt_nxt;
      if_cnt_r <= if_cnt_nxt;
      ctl_r    <= ctl_nxt;
    end
  end

  // R5: pin low clears at once
  assign pwr_clear = reset_i | ~chip_enable_i;
  // R4: enable then programmed bits
  // R12: synchronous power-down bits
  assign rf_pwr_nxt = ce_s2_r & ~ctl_r[CTL_RF][PD_BIT];
  assign if_pwr_nxt = ce_s2_r & ~ctl_r[CTL_IF][PD_BIT];

  always_ff @(posedge mclk_i or posedge pwr_clear)
  begin
    if (pwr_clear)
    begin
      rf_power_on_o      <= 1'b0;
      if_power_on_o      <= 1'b0;
      rf_pump_out_oe_n_o <= 1'b1;
      if_pump_out_oe_n_o <= 1'b1;
    end
    else
    begin
      rf_power_on_o      <= rf_pwr_nxt;
      if_power_on_o      <= if_pwr_nxt;
      rf_pump_out_oe_n_o <= ~rf_pwr_nxt;
      if_pump_out_oe_n_o <= ~if_pwr_nxt;
    end
  end

  // Settings and shared pins.
  always_comb
  begin
    // R6: oscillator buffer kept on
    oscb_nxt = osc_s2_r | ce_s2_r;
    oscm_nxt = osc_s2_r;
    // R10: pump current level
    rfh_nxt = ctl_r[CTL_RF][CUR_BIT];
    ifh_nxt = ctl_r[CTL_IF][CUR_BIT];
    // R9: prescaler modulus choice
    rfm_nxt = ctl_r[CTL_RF][PRE_BIT] ? MOD_16 : (cfg_r[CFG_HF_BIT] ? MOD_32 : MOD_8);
    ifm_nxt = ctl_r[CTL_IF][PRE_BIT] ? MOD_16 : MOD_8;
    // R8: switch or general output
    rff_nxt   = ctl_r[CTL_PIN][RF_GPO_BIT] ? ctl_r[CTL_PIN][RF_GPO_VAL] : 1'b0;
    rffoe_nxt = ctl_r[CTL_PIN][RF_GPO_BIT] ? ctl_r[CTL_PIN][RF_GPO_TRI] : (rf_cnt_r == 16'h0000);
    // R7: shared pin as IF switch
    iff_nxt   = ctl_r[CTL_PIN][IF_GPO_BIT] ? ctl_r[CTL_PIN][IF_GPO_VAL] : 1'b0;
    iffoe_nxt = ctl_r[CTL_PIN][IF_GPO_BIT] ? ctl_r[CTL_PIN][IF_GPO_TRI] : (if_cnt_r == 16'h0000);
    if (osc_s2_r)
    begin
      iff_nxt   = 1'b0;
      iffoe_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      osc_buffer_on_o                  <= 1'b0;
      osc_out_mode_o                   <= 1'b0;
      rf_pump_high_o                   <= 1'b0;
      if_pump_high_o                   <= 1'b0;
      rf_modulus_o                     <= MOD_8;
      if_modulus_o                     <= MOD_8;
      rf_fast_switch_out_o             <= 1'b0;
      rf_fast_switch_out_oe_n_o        <= 1'b1;
      osc_out_or_if_fast_switch_o      <= 1'b0;
      osc_out_or_if_fast_switch_oe_n_o <= 1'b1;
    end
    else
    begin
      osc_buffer_on_o                  <= oscb_nxt;
      osc_out_mode_o                   <= oscm_nxt;
      rf_pump_high_o                   <= rfh_nxt;
      if_pump_high_o                   <= ifh_nxt;
      rf_modulus_o                     <= rfm_nxt;
      if_modulus_o                     <= ifm_nxt;
      rf_fast_switch_out_o             <= rff_nxt;
      rf_fast_switch_out_oe_n_o        <= rffoe_nxt;
      osc_out_or_if_fast_switch_o      <= iff_nxt;
      osc_out_or_if_fast_switch_oe_n_o <= iffoe_nxt;
    end
  end

  // Register read multiplexer.
  function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[ADDR_W-1:2];
    read_word = {1'b0, 32'h0000_0000};
    if (idx < 6'(NUM_CTL))
      read_word = {1'b0, 8'h00, ctl_r[idx[2:0]]};
    else if (idx == IDX_STATUS)
      read_word = {1'b0, 16'h0000, loads_r, 2'b00, (if_cnt_r != 16'h0000),
                   (rf_cnt_r != 16'h0000), if_power_on_o, rf_power_on_o, osc_s2_r, ce_s2_r};
    else if (idx == IDX_CONFIG)
      read_word = {1'b0, cfg_r};
    else
      read_word = {1'b1, 32'h0000_0000};
  endfunction

  // AXI4-Lite write and read channels.
  always_comb
  begin
    rd_word = read_word(s_axi_araddr_i);
    awh_nxt = awh_r;
    awa_nxt = awa_r;
    wh_nxt  = wh_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = s_axi_bvalid_o;
    br_nxt  = s_axi_bresp_o;
    cfg_nxt = cfg_r;
    arr_nxt = s_axi_arready_o;
    rv_nxt  = s_axi_rvalid_o;
    rd_nxt  = s_axi_rdata_o;
    rr_nxt  = s_axi_rresp_o;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      awh_nxt = 1'b1;
      awa_nxt = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata_i;
      ws_nxt = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i)
      bv_nxt = 1'b0;
    if (awh_r && wh_r && !s_axi_bvalid_o)
    begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = RESP_SLVERR;
      if (awa_r[ADDR_W-1:2] == IDX_CONFIG)
      begin
        br_nxt = RESP_OKAY;
        for (int b = 0; b < 4; b++)
          if (ws_r[b])
            cfg_nxt[8*b +: 8] = wd_r[8*b +: 8];
        cfg_nxt = cfg_nxt & CFG_MASK;
      end
      else if (awa_r[ADDR_W-1:2] <= IDX_STATUS)
        br_nxt = RESP_SLVERR;
    end
    awr_nxt = ~awh_nxt & ~bv_nxt;
    wr_nxt  = ~wh_nxt & ~bv_nxt;
    if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      rv_nxt  = 1'b0;
      arr_nxt = 1'b1;
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      arr_nxt = 1'b0;
      rv_nxt  = 1'b1;
      rd_nxt  = rd_word[31:0];
      rr_nxt  = rd_word[32] ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      {awh_r, wh_r}   <= 2'b00;
      awa_r           <= 8'h00;
      wd_r            <= 32'h0000_0000;
      ws_r            <= 4'h0;
      cfg_r           <= CFG_RESET;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end
    else
    begin
      {awh_r, wh_r}   <= {awh_nxt, wh_nxt};
      awa_r           <= awa_nxt;
      wd_r            <= wd_nxt;
      ws_r            <= ws_nxt;
      cfg_r           <= cfg_nxt;
      s_axi_awready_o <= awr_nxt;
      s_axi_wready_o  <= wr_nxt;
      s_axi_bvalid_o  <= bv_nxt;
      s_axi_bresp_o   <= br_nxt;
      s_axi_arready_o <= arr_nxt | (~s_axi_arready_o & ~s_axi_rvalid_o & ~rv_nxt);
      s_axi_rvalid_o  <= rv_nxt;
      s_axi_rdata_o   <= rd_nxt;
      s_axi_rresp_o   <= rr_nxt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_load_rf;
    load_ok && (load_idx == CTL_RF);
  endsequence
  sequence s_fast_start;
    rf_start && ce_s2_r;
  endsequence

  property p_shift_in;
    sck_rise |=> (shift_r[0] == $past(dat_s2_r))
                 && (shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift register missed a bit"); // R1 R13
  property p_latch;
    load_ok |=> ctl_r[$past(load_idx)] == $past(shift_r);
  endproperty
  a_latch: assert property (p_latch) else $error("control register not loaded"); // R2 R3
  property p_power_up;
    (ce_s2_r && chip_enable_i && !ctl_r[CTL_RF][PD_BIT]) ##1 chip_enable_i
      |-> rf_power_on_o && !rf_pump_out_oe_n_o;
  endproperty
  a_power_up: assert property (p_power_up) else $error("RF section not powered"); // R4
  property p_pin_down;
    !chip_enable_i |-> !rf_power_on_o && !if_power_on_o && rf_pump_out_oe_n_o && if_pump_out_oe_n_o;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("chip enable low but powered"); // R5
  property p_osc_on;
    osc_s2_r |=> osc_buffer_on_o && osc_out_mode_o && osc_out_or_if_fast_switch_oe_n_o;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator buffer off"); // R6
  property p_if_switch;
    (!osc_s2_r && !ctl_r[CTL_PIN][IF_GPO_BIT])
      |=> osc_out_or_if_fast_switch_oe_n_o == ($past(if_cnt_r) == 16'h0000);
  endproperty
  a_if_switch: assert property (p_if_switch) else $error("IF fast switch wrong"); // R7
  property p_rf_gpo;
    ctl_r[CTL_PIN][RF_GPO_BIT] |=> rf_fast_switch_out_o == $past(ctl_r[CTL_PIN][RF_GPO_VAL]);
  endproperty
  a_rf_gpo: assert property (p_rf_gpo) else $error("RF general output wrong"); // R8
  property p_modulus;
    (ctl_r[CTL_RF][PRE_BIT] == 1'b0 && cfg_r[CFG_HF_BIT]) |=> rf_modulus_o == MOD_32;
  endproperty
  a_modulus: assert property (p_modulus) else $error("RF modulus wrong"); // R9
  property p_current;
    s_load_rf ##2 1'b1 |-> rf_pump_high_o == $past(shift_r[CUR_BIT], 2);
  endproperty
  a_current: assert property (p_current) else $error("pump current not applied"); // R10
  property p_fast;
    s_fast_start |=> rf_cnt_r == $past(tmo);
  endproperty
  a_fast: assert property (p_fast) else $error("fastlock did not start"); // R11
  property p_sync_down;
    (ctl_r[CTL_RF][PD_BIT] && ctl_r[CTL_IF][PD_BIT]) |=> !rf_power_on_o && !if_power_on_o;
  endproperty
  a_sync_down: assert property (p_sync_down) else $error("power-down bits ignored"); // R12
endmodule

// [bench/ssp_host_model.sv]
`timescale 1ns/100ps
module ssp_host_model (
  // Clock.
  input  wire logic mclk_i,
  // Serial programming port.
  output logic      serial_clk_o,
  output logic      serial_data_o,
  output logic      latch_strobe_o
);
  initial
  begin
    serial_clk_o   = 1'h0;
    serial_data_o  = 1'h0;
    latch_strobe_o = 1'h0;
  end

  task automatic shift_bits(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge mclk_i);
      serial_clk_o  <= 1'h0;
      serial_data_o <= bits[i];
      repeat (4) @(posedge mclk_i);
      serial_clk_o <= 1'h1;
      repeat (3) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    serial_clk_o <= 1'h0;
    repeat (3) @(posedge mclk_i);
    serial_data_o <= ~serial_data_o;
  endtask

  task automatic pulse_strobe();
    @(posedge mclk_i);
    latch_strobe_o <= 1'h1;
    repeat (8) @(posedge mclk_i);
    latch_strobe_o <= 1'h0;
  endtask
endmodule

// [bench/synth_serial_program_power_ctrl_tb.sv]
`timescale 1ns/100ps
module synth_serial_program_power_ctrl_tb;
  import ssp_pkg::*;
  logic        mclk, rst, sclk, sdata, strobe, ce, osc_en;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        rf_pwr, if_pwr, osc_on, osc_mode, rf_cp_oe_n, if_cp_oe_n, rf_hi, if_hi;
  logic [5:0]  rf_mod, if_mod;
  logic        rf_fs, rf_fs_oe_n, sh_pin, sh_oe_n;
  logic [23:0] w;
  int          n_fail, n_tests;

  ssp_top uut (
    .mclk_i(mclk), .reset_i(rst), .serial_clk_i(sclk), .serial_data_i(sdata),
    .latch_strobe_i(strobe), .chip_enable_i(ce), .osc_buffer_enable_i(osc_en),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rf_power_on_o(rf_pwr),
    .if_power_on_o(if_pwr), .osc_buffer_on_o(osc_on), .osc_out_mode_o(osc_mode),
    .rf_pump_out_oe_n_o(rf_cp_oe_n), .if_pump_out_oe_n_o(if_cp_oe_n),
    .rf_pump_high_o(rf_hi), .if_pump_high_o(if_hi), .rf_modulus_o(rf_mod),
    .if_modulus_o(if_mod), .rf_fast_switch_out_o(rf_fs),
    .rf_fast_switch_out_oe_n_o(rf_fs_oe_n), .osc_out_or_if_fast_switch_o(sh_pin),
    .osc_out_or_if_fast_switch_oe_n_o(sh_oe_n)
  );

  ssp_host_model host (
    .mclk_i(mclk), .serial_clk_o(sclk), .serial_data_o(sdata), .latch_strobe_o(strobe)
  );

  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    chk(name, {30'h0, exp}, {30'h0, got});
  endtask

  task automatic hang(input string name);
    n_fail++;
    $display("unexpected %s: expected an answer, seen none", name);
    tally_and_finish();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge mclk);
      k++;
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && k < 100);
    if (bvalid !== 1'h1)
      hang("bvalid");
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] exp_rs);
    int k;
    k = 0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge mclk);
      k++;
      if (arvalid && arready)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && k < 100);
    if (rvalid !== 1'h1)
      hang("rvalid");
    chk(name, exp, rdata);
    chk_resp(name, exp_rs, rresp);
    rready <= 1'h0;
  endtask

  task automatic prog(input logic [31:0] bits, input int n);
    host.shift_bits(bits, n);
    host.pulse_strobe();
    #1;
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    hang("run");
  end

  initial
  begin
    rst = 1'h1;
    ce = 1'h0;
    osc_en = 1'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk("reset pins", 32'({rf_pwr, if_pwr, rf_cp_oe_n, if_cp_oe_n, rf_fs_oe_n, rf_mod, if_mod}),
        32'({5'h07, MOD_8, MOD_8}));
    rd_chk("config reset", {IDX_CONFIG, 2'h0}, CFG_RESET, RESP_OKAY);
    axi_write({IDX_CONFIG, 2'h0}, 32'h0000_0020, r);
    chk_resp("config write", RESP_OKAY, r);
    rd_chk("config", {IDX_CONFIG, 2'h0}, 32'h0000_0020, RESP_OKAY);
    axi_write(8'h00, 32'hffff_ffff, r);
    chk_resp("read only write", RESP_SLVERR, r);
    rd_chk("ctl0 reset", 8'h00, {8'h00, CTL_RESET}, RESP_OKAY);
    rd_chk("unmapped", 8'h40, 32'h0000_0000, RESP_SLVERR);
    @(posedge mclk);
    ce <= 1'h1;
    repeat (4) @(posedge mclk);
    w = {1'h0, 1'h1, 1'h1, 19'h0_1234, 2'h0};
    prog(32'(w), 24);
    chk("rf controls", 32'({rf_pwr, rf_cp_oe_n, rf_hi, rf_mod}), 32'({3'h5, MOD_16}));
    chk("rf fast pin", 32'({rf_fs_oe_n, rf_fs}), 32'h0000_0000);
    rd_chk("status", {IDX_STATUS, 2'h0}, 32'h0000_0115, RESP_OKAY);
    rd_chk("ctl0", 8'h00, {8'h00, w}, RESP_OKAY);
    repeat (40) @(posedge mclk);
    #1;
    chk("rf fast end", 32'(rf_fs_oe_n), 32'h0000_0001);
    w = {3'h0, 19'h0_0100, 2'h1};
    prog({4'h0, 4'ha, w}, 28);
    chk("if controls", 32'({if_pwr, if_cp_oe_n, if_hi, if_mod, sh_oe_n, sh_pin, osc_mode}),
        32'({3'h4, MOD_8, 3'h0}));
    rd_chk("ctl1", 8'h04, {8'h00, w}, RESP_OKAY);
    for (int s = 0; s < 3; s++)
    begin
      w = {8'h5a, 12'(s), 2'(s), 2'h3};
      prog(32'(w), 24);
      rd_chk("ctl ext", 8'(4 * (3 + s)), {8'h00, w}, RESP_OKAY);
    end
    prog(32'h005a_0fff, 24);
    rd_chk("ctl5 kept", 8'h14, {8'h00, w}, RESP_OKAY);
    prog(32'h00c0_0002, 24);
    chk("rf pin out", 32'({rf_fs_oe_n, rf_fs}), 32'h0000_0001);
    prog(32'h00a0_0002, 24);
    chk("rf pin tri", 32'(rf_fs_oe_n), 32'h0000_0001);
    prog(32'h0018_0002, 24);
    chk("shared pin out", 32'({sh_oe_n, sh_pin}), 32'h0000_0001);
    axi_write({IDX_CONFIG, 2'h0}, 32'h0001_0020, r);
    chk_resp("config hf", RESP_OKAY, r);
    prog(32'({3'h0, 19'h0_1235, 2'h0}), 24);
    chk("rf high band", 32'({rf_pwr, rf_hi, rf_mod}), 32'({2'h2, MOD_32}));
    prog(32'h0080_0000, 24);
    chk("rf sync down", 32'({rf_pwr, if_pwr}), 32'h0000_0001);
    @(posedge mclk);
    ce <= 1'h0;
    osc_en <= 1'h1;
    #1;
    chk("async down", 32'({if_pwr, rf_cp_oe_n, if_cp_oe_n}), 32'h0000_0003);
    repeat (4) @(posedge mclk);
    #1;
    chk("osc buffer", 32'({osc_on, osc_mode, sh_oe_n}), 32'h0000_0007);
    @(posedge mclk);
    ce <= 1'h1;
    repeat (5) @(posedge mclk);
    #1;
    chk("power back", 32'({if_pwr, rf_pwr}), 32'h0000_0002);
    tally_and_finish();
  end
endmodule
